//--- cap_touch_option_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module cap_touch_option_decoder
   import touch_option_pkg::*;
#(
   parameter int CH = 3,
   parameter int CW = 16
) (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               resetn,
   // option byte programming
   input  wire logic [7:0]         option_bank_zero,
   input  wire logic               wr_bank_one,
   input  wire logic               wr_bank_two,
   input  wire logic               wr_bank_three,
   input  wire logic [7:0]         wr_data,
   output logic      [7:0]         option_bank_one,
   output logic      [7:0]         option_bank_two,
   output logic      [7:0]         option_bank_three,
   // tuning engine results used in full mode
   input  wire logic [1:0]         auto_sens_multiplier,
   input  wire logic [3:0]         auto_base_multiplier,
   // per channel sample stream
   input  wire logic               sample_valid,
   input  wire logic [CH*CW-1:0]   sample_count,
   input  wire logic [CH*CW-1:0]   long_term_average,
   // decoded configuration
   output var option_cfg_t         cfg,
   output logic      [1:0]         tuning_multiplier_sens,
   output logic      [3:0]         tuning_multiplier_base,
   output logic      [CH*CW-1:0]   touch_threshold,
   // touch outputs, pin form
   output logic      [CH-1:0]      touch_active,
   output logic      [CH-1:0]      touch_pin_out,
   output logic      [CH-1:0]      touch_pin_oe
);

   // ==========================================================
   // option bytes
   logic [7:0] next_b1, next_b2, next_b3;

   always_comb begin
      next_b1 = option_bank_one;
      next_b2 = option_bank_two;
      next_b3 = option_bank_three;
      if (wr_bank_one) begin
         next_b1 = wr_data;
      end
      if (wr_bank_two) begin
         next_b2 = wr_data;
      end
      if (wr_bank_three) begin
         next_b3 = wr_data;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         option_bank_one   <= BANK_RESET;
         option_bank_two   <= BANK_RESET;
         option_bank_three <= BANK_RESET;
      end else begin
         option_bank_one   <= next_b1;
         option_bank_two   <= next_b2;
         option_bank_three <= next_b3;
      end
   end

   // ==========================================================
   // decode; registered so the fields never glitch mid-sample
   option_cfg_t next_cfg;
   logic        partial;
   logic        alt_base;
   logic [1:0]  pcode;

   assign partial  = option_bank_zero[BANK0_METHOD_BIT];
   assign alt_base = option_bank_two[BANK2_BASE_RANGE_SELECT_BIT];
   assign pcode    = option_bank_one[BANK1_PBASE_LSB +: 2];

   always_comb begin
      next_cfg = '0;
      next_cfg.partial_tuning = partial;
      case (pcode)
         2'h0:    next_cfg.prox_base = alt_base ? PBASE_ALT0 : PBASE_DEF0;
         2'h1:    next_cfg.prox_base = alt_base ? PBASE_ALT1 : PBASE_DEF1;
         2'h2:    next_cfg.prox_base = alt_base ? PBASE_ALT2 : PBASE_DEF2;
         default: next_cfg.prox_base = alt_base ? PBASE_ALT3 : PBASE_DEF3;
      endcase
      // in partial mode bits 1:0 are base multiplier bits, base is code zero of the range alt_base selects
      if (partial) begin
         next_cfg.prox_base = alt_base ? PBASE_ALT0 : PBASE_DEF0;
      end
      next_cfg.touch_base = option_bank_zero[BANK0_TBASE_BIT]
                            ? TBASE_ALT : TBASE_DEF;
      next_cfg.halt_code = option_bank_one[BANK1_HALT_LSB +: 2];
      case (next_cfg.halt_code)
         2'h0:    next_cfg.halt_seconds = 6'(HALT_SHORT_S);
         2'h1:    next_cfg.halt_seconds = 6'(HALT_LONG_S);
         2'h2:    next_cfg.halt_seconds = 6'h00;
         default: next_cfg.halt_seconds = 6'(HALT_LONG_S);
      endcase
      if (partial) begin
         next_cfg.sens_multiplier = option_bank_one[BANK1_SENS_LSB +: 2];
         next_cfg.base_multiplier = option_bank_one[BANK1_BASEMUL_LSB +: 4];
      end else begin
         next_cfg.sens_multiplier = auto_sens_multiplier;
         next_cfg.base_multiplier = auto_base_multiplier;
      end
      next_cfg.charge_frequency_select =
         option_bank_two[BANK2_FREQ_BIT];
      next_cfg.stream_enable = option_bank_two[BANK2_STREAM_BIT];
      next_cfg.rf_noise_block_enable =
         option_bank_two[BANK2_NOISE_BIT];
      next_cfg.sample_period_select =
         option_bank_two[BANK2_PERIOD_LSB +: 2];
      case (next_cfg.sample_period_select)
         2'h0:    next_cfg.sample_period_ms = 10'(PERIOD_BOOST_MS);
         2'h1:    next_cfg.sample_period_ms = 10'(PERIOD_NORM_MS);
         2'h2:    next_cfg.sample_period_ms = 10'(PERIOD_LP1_MS);
         default: next_cfg.sample_period_ms = 10'(PERIOD_LP2_MS);
      endcase
      next_cfg.guard_channel_enable =
         option_bank_two[BANK2_GUARD_BIT];
      next_cfg.active_high = option_bank_two[BANK2_POL_BIT];
      next_cfg.retune_delay_s = option_bank_three[BANK3_DELAY_BIT]
                                ? 4'(RETUNE_DELAY_S) : 4'h0;
      if (option_bank_three[BANK3_TARGET_BIT]) begin
         next_cfg.prox_target  = TGT_PROX_LO;
         next_cfg.touch_target = TGT_TOUCH_LO;
      end else begin
         next_cfg.prox_target  = TGT_PROX_HI;
         next_cfg.touch_target = TGT_TOUCH_HI;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfg <= '0;
      end else begin
         cfg <= next_cfg;
      end
   end

   assign tuning_multiplier_sens = cfg.sens_multiplier;
   assign tuning_multiplier_base = cfg.base_multiplier;

   // ==========================================================
   // thresholds and touch detection
   logic [2:0]    thr_code [CH];
   logic [CW-1:0] next_thr [CH];
   logic [CH-1:0] meets;
   logic [CH-1:0] next_active;
   logic [CH-1:0] next_pin_out;
   logic [CH-1:0] next_pin_oe;
   detect_state_t det     [CH];
   detect_state_t next_det[CH];

   always_comb begin
      for (int i = 0; i < CH; i++) begin
         logic [CW-1:0]   avg;
         logic [CW-1:0]   smp;
         logic [CW+5:0]   prod;
         avg = long_term_average[i*CW +: CW];
         smp = sample_count[i*CW +: CW];
         // channel one takes its own code only in full mode
         if (i == 1 && !partial) begin
            thr_code[i] = option_bank_one[BANK1_THR_LSB +: 3];
         end else begin
            thr_code[i] = option_bank_zero[BANK0_THR_LSB +: 3];
         end
         prod = avg * thr_fraction(thr_code[i]);
         next_thr[i] = CW'(prod >> FRAC_SHIFT);
         // sample above average never counts as a touch
         meets[i] = (avg >= smp) && ((avg - smp) >= next_thr[i]);
         next_det[i] = det[i];
         if (sample_valid) begin
            case (det[i])
               DET_IDLE:  next_det[i] = meets[i] ? DET_ONE : DET_IDLE;
               DET_ONE:   next_det[i] = meets[i] ? DET_TOUCH : DET_IDLE;
               DET_TOUCH: next_det[i] = meets[i] ? DET_TOUCH : DET_IDLE;
               default:   next_det[i] = DET_IDLE;
            endcase
         end
         next_active[i] = (next_det[i] == DET_TOUCH);
         if (cfg.active_high) begin
            next_pin_out[i] = next_active[i];
            next_pin_oe[i]  = 1'b1;
         end else begin // open drain: only ever pull low
            next_pin_out[i] = 1'b0;
            next_pin_oe[i]  = next_active[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < CH; i++) begin
            det[i] <= DET_IDLE;
         end
         touch_threshold <= '0;
         touch_active    <= '0;
         touch_pin_out   <= '0;
         touch_pin_oe    <= '0;
      end else begin
         for (int i = 0; i < CH; i++) begin
            det[i] <= next_det[i];
            touch_threshold[i*CW +: CW] <= next_thr[i];
         end
         touch_active  <= next_active;
         touch_pin_out <= next_pin_out;
         touch_pin_oe  <= next_pin_oe;
      end
   end

   // ==========================================================
   // checks
   // independent memory of the last valid sample on channel zero;
   // idle cycles between samples leave it alone
   logic prev_hit;
   logic next_prev_hit;

   always_comb begin
      next_prev_hit = prev_hit;
      if (sample_valid) begin
         next_prev_hit = meets[0];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prev_hit <= 1'b0;
      end else begin
         prev_hit <= next_prev_hit;
      end
   end

   sequence two_hits;
      sample_valid && meets[0] && prev_hit;
   endsequence

   a_touch_needs_two: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(touch_active[0]) |-> $past(det[0]) == DET_ONE)
      else $error("touch declared without two qualifying samples");
   a_touch_after_two: assert property (@(posedge clk_sys) disable iff (!resetn)
      two_hits |=> touch_active[0])
      else $error("two qualifying samples gave no touch");
   a_touch_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
      sample_valid && !meets[0] |=> !touch_active[0])
      else $error("touch held after failing sample");
   a_prox_base: assert property (@(posedge clk_sys) disable iff (!resetn)
      !partial && !alt_base && pcode == 2'h1 |=> cfg.prox_base == PBASE_DEF1)
      else $error("proximity base decode wrong");
   a_prox_alt: assert property (@(posedge clk_sys) disable iff (!resetn)
      !partial && alt_base && pcode == 2'h3 |=> cfg.prox_base == PBASE_ALT3)
      else $error("alternate proximity base wrong");
   a_partial_mult: assert property (@(posedge clk_sys) disable iff (!resetn)
      partial |=> cfg.base_multiplier == $past(option_bank_one[3:0]))
      else $error("partial multiplier not from option byte");
   a_full_mult: assert property (@(posedge clk_sys) disable iff (!resetn)
      !partial |=> cfg.sens_multiplier == $past(auto_sens_multiplier))
      else $error("full mode multiplier not from tuning");
   a_ch1_code: assert property (@(posedge clk_sys) disable iff (!resetn)
      partial |-> thr_code[1] == thr_code[0])
      else $error("channel one threshold split in partial mode");
   a_halt_never: assert property (@(posedge clk_sys) disable iff (!resetn)
      option_bank_one[7:6] == 2'h2 |=> cfg.halt_seconds == 6'h00)
      else $error("never halt decode wrong");
   a_period_lp2: assert property (@(posedge clk_sys) disable iff (!resetn)
      option_bank_two[3:2] == 2'h3 |=> cfg.sample_period_ms == 10'd1000)
      else $error("sample period decode wrong");
   a_target_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
      option_bank_three[0] |=> cfg.touch_target == TGT_TOUCH_LO)
      else $error("target count decode wrong");
   a_open_drain: assert property (@(posedge clk_sys) disable iff (!resetn)
      !cfg.active_high && !$past(cfg.active_high)
         |-> (touch_pin_oe & touch_pin_out) == '0)
      else $error("open drain output driven high");
   a_touch_base: assert property (@(posedge clk_sys) disable iff (!resetn)
      option_bank_zero[BANK0_TBASE_BIT] |=> cfg.touch_base == TBASE_ALT)
      else $error("touch base decode wrong");
   a_halt_short: assert property (@(posedge clk_sys) disable iff (!resetn)
      option_bank_one[BANK1_HALT_LSB +: 2] == 2'h0
         |=> cfg.halt_seconds == 6'(HALT_SHORT_S))
      else $error("short halt decode wrong");

endmodule : cap_touch_option_decoder
`default_nettype wire

//--- tb_cap_touch_option_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cap_touch_option_decoder;
   import touch_option_pkg::*;
   // =========================================================
   // signals
   logic        clk_sys = 1'b0;
   logic        resetn  = 1'b0;
   logic [7:0]  bank0   = 8'h00;
   logic [2:0]  wr      = 3'h0;
   logic [7:0]  wdata   = 8'h00;
   logic [1:0]  a_sens  = 2'h0;
   logic [3:0]  a_base  = 4'h0;
   logic        go      = 1'b0;
   logic [47:0] cs_in   = 48'h0;
   logic [47:0] lta_in  = 48'h0;
   logic [7:0]  d1, d2, d3, b1, b2, b3;
   logic [1:0]  m_sens;
   logic [3:0]  m_base;
   logic [47:0] thr, sc, la;
   logic [2:0]  t_act, p_out, p_oe, p_lvl;
   logic        sv;
   logic [31:0] r;
   option_cfg_t cfg;
   int          num_errors = 0;
   int          n_compared = 0;
   int          seed       = 58848;

   always #5 clk_sys = ~clk_sys;

   cap_touch_option_decoder uut (.clk_sys(clk_sys), .resetn(resetn),
      .option_bank_zero(bank0), .wr_bank_one(wr[0]), .wr_bank_two(wr[1]),
      .wr_bank_three(wr[2]), .wr_data(wdata), .option_bank_one(b1),
      .option_bank_two(b2), .option_bank_three(b3),
      .auto_sens_multiplier(a_sens), .auto_base_multiplier(a_base),
      .sample_valid(sv), .sample_count(sc), .long_term_average(la),
      .cfg(cfg), .tuning_multiplier_sens(m_sens),
      .tuning_multiplier_base(m_base), .touch_threshold(thr),
      .touch_active(t_act), .touch_pin_out(p_out), .touch_pin_oe(p_oe));

   touch_partner far_side (.clk_sys(clk_sys), .resetn(resetn), .go(go),
      .cs_in(cs_in), .lta_in(lta_in), .sample_valid(sv),
      .sample_count(sc), .long_term_average(la), .pin_out(p_out),
      .pin_oe(p_oe), .pin_level(p_lvl));

   // =========================================================
   // expectations
   function automatic logic [5:0] frac_of(input logic [2:0] c);
      case (c)
         3'h0: frac_of = 6'h04;
         3'h1: frac_of = 6'h01;
         3'h2: frac_of = 6'h02;
         3'h3: frac_of = 6'h08;
         3'h4: frac_of = 6'h0C;
         3'h5: frac_of = 6'h10;
         3'h6: frac_of = 6'h18;
         default: frac_of = 6'h20;
      endcase
   endfunction : frac_of

   function automatic logic [9:0] pbase_of(input logic [2:0] c);
      case (c)
         3'h0: pbase_of = 10'h0C8;
         3'h1: pbase_of = 10'h032;
         3'h2: pbase_of = 10'h064;
         3'h3: pbase_of = 10'h0FA;
         3'h4: pbase_of = 10'h096;
         3'h5: pbase_of = 10'h15E;
         3'h6: pbase_of = 10'h1F4;
         default: pbase_of = 10'h2BC;
      endcase
   endfunction : pbase_of

   function automatic logic [15:0] exp_thr(input int i,
                                           input logic [15:0] avg);
      logic [2:0]  code;
      logic [21:0] p;
      code = (i == 1 && !bank0[7]) ? d1[4:2] : bank0[4:2];
      p = 22'(frac_of(code)) * 22'(avg);
      return p[21:6];
   endfunction : exp_thr

   // =========================================================
   // drivers and checks
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step

   task automatic do_reset();
      resetn = 1'b0;
      step(8);
      check({b1, b2, b3, t_act}, 27'h0);
      resetn = 1'b1;
      step(1);
   endtask : do_reset

   task automatic program_banks();
      wdata = d1;
      wr = 3'h1;
      step(1);
      wdata = d2;
      wr = 3'h2;
      step(1);
      wdata = d3;
      wr = 3'h4;
      step(1);
      wr = 3'h0;
      step(2);
   endtask : program_banks

   task automatic check_cfg();
      logic pt;
      pt = bank0[7];
      check({b1, b2, b3}, {d1, d2, d3});
      check(cfg.prox_base, pbase_of({d2[7], pt ? 2'h0 : d1[1:0]}));
      check(cfg.touch_base, bank0[5] ? 8'h64 : 8'hFA);
      check(cfg.halt_code, d1[7:6]);
      check(cfg.halt_seconds, (d1[7:6] == 2'h2) ? 6'h00
                              : (d1[6] ? 6'h28 : 6'h14));
      check(cfg.partial_tuning, pt);
      check({m_sens, m_base}, pt ? d1[5:0] : {a_sens, a_base});
      check(cfg.charge_frequency_select, d2[6]);
      check({cfg.stream_enable, cfg.rf_noise_block_enable}, d2[5:4]);
      check(cfg.sample_period_select, d2[3:2]);
      check(cfg.sample_period_ms, d2[3] ? (d2[2] ? 10'h3E8 : 10'h080)
                                        : (d2[2] ? 10'h020 : 10'h009));
      check(cfg.guard_channel_enable, d2[1]);
      check(cfg.active_high, d2[0]);
      check(cfg.retune_delay_s, d3[1] ? 4'hA : 4'h0);
      check({cfg.prox_target, cfg.touch_target},
            d3[0] ? {11'h200, 11'h100} : {11'h400, 11'h200});
      for (int i = 0; i < 3; i++)
         check(thr[i*16+:16], exp_thr(i, lta_in[i*16+:16]));
   endtask : check_cfg

   task automatic sample(input logic [47:0] cs);
      cs_in = cs;
      go = 1'b1;
      step(1);
      go = 1'b0;
      step(1);
   endtask : sample

   // two samples; adj 1 misses the threshold by one count
   task automatic touch_trial(input logic ah, input logic [2:0] code,
      input logic [15:0] adj, input logic gap, input logic again);
      logic [47:0] cs;
      logic [2:0]  t;
      do_reset();
      r = $random(seed);
      bank0 = {3'h0, code, 2'h0};
      lta_in = {4'h4, r[11:0], 4'h5, r[23:12], 8'h60, r[31:24]};
      d1 = 8'h00;
      d2 = {7'h00, ah};
      d3 = 8'h00;
      program_banks();
      for (int i = 0; i < 3; i++)
         cs[i*16+:16] = lta_in[i*16+:16] - exp_thr(i, lta_in[i*16+:16]) + adj;
      sample(cs);
      check(t_act, 3'h0);
      if (gap) step(3);
      sample(again ? cs : lta_in);
      t = (again && adj == 16'h0) ? 3'h7 : 3'h0;
      check(t_act, t);
      check({p_lvl, p_oe}, ah ? {t, 3'h7} : {~t, t});
   endtask : touch_trial

   task automatic wrap_up();
      if (num_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   // =========================================================
   // sequence
   initial begin
      do_reset();
      for (int k = 0; k < 40; k++) begin
         r = $random(seed);
         bank0 = r[7:0];
         {a_sens, a_base} = r[13:8];
         lta_in = 48'({$random(seed), $random(seed)});
         r = (k < 2) ? {32{k[0]}} : $random(seed);
         {d1, d2, d3} = r[23:0];
         if (k < 2) bank0 = r[7:0];
         program_banks();
         check_cfg();
      end
      do_reset();
      for (int c = 0; c < 8; c++)
         touch_trial(c[0], 3'(c), 16'h0, c[1], 1'b1);
      touch_trial(1'b0, 3'h3, 16'h1, 1'b0, 1'b1);
      touch_trial(1'b1, 3'h5, 16'h0, 1'b0, 1'b0);
      wrap_up();
   end

   initial begin
      #100000;
      num_errors++;
      wrap_up();
   end
endmodule : tb_cap_touch_option_decoder
`default_nettype wire

//--- touch_option_pkg.sv
package touch_option_pkg;
   // ==========================================================
   // option byte field positions
   localparam int BANK0_METHOD_BIT   = 7;
   localparam int BANK0_TBASE_BIT    = 5;
   localparam int BANK0_THR_LSB      = 2;
   localparam int BANK1_HALT_LSB     = 6;
   localparam int BANK1_THR_LSB      = 2;
   localparam int BANK1_PBASE_LSB    = 0;
   localparam int BANK1_SENS_LSB     = 4;
   localparam int BANK1_BASEMUL_LSB  = 0;
   localparam int BANK2_BASE_RANGE_SELECT_BIT  = 7;
   localparam int BANK2_FREQ_BIT     = 6;
   localparam int BANK2_STREAM_BIT   = 5;
   localparam int BANK2_NOISE_BIT    = 4;
   localparam int BANK2_PERIOD_LSB   = 2;
   localparam int BANK2_GUARD_BIT    = 1;
   localparam int BANK2_POL_BIT      = 0;
   localparam int BANK3_DELAY_BIT    = 1;
   localparam int BANK3_TARGET_BIT   = 0;
   // unprogrammed option bytes read as zero
   localparam logic [7:0] BANK_RESET = 8'h00;

   // ==========================================================
   // values
   localparam logic [9:0] PBASE_DEF0 = 10'd200;
   localparam logic [9:0] PBASE_DEF1 = 10'd50;
   localparam logic [9:0] PBASE_DEF2 = 10'd100;
   localparam logic [9:0] PBASE_DEF3 = 10'd250;
   localparam logic [9:0] PBASE_ALT0 = 10'd150;
   localparam logic [9:0] PBASE_ALT1 = 10'd350;
   localparam logic [9:0] PBASE_ALT2 = 10'd500;
   localparam logic [9:0] PBASE_ALT3 = 10'd700;
   localparam logic [7:0] TBASE_DEF  = 8'd250;
   localparam logic [7:0] TBASE_ALT  = 8'd100;
   localparam logic [10:0] TGT_PROX_HI  = 11'd1024;
   localparam logic [10:0] TGT_PROX_LO  = 11'd512;
   localparam logic [10:0] TGT_TOUCH_HI = 11'd512;
   localparam logic [10:0] TGT_TOUCH_LO = 11'd256;
   localparam int HALT_SHORT_S    = 20;
   localparam int HALT_LONG_S     = 40;
   localparam int RETUNE_DELAY_S  = 10;
   localparam int PERIOD_BOOST_MS = 9;
   localparam int PERIOD_NORM_MS  = 32;
   localparam int PERIOD_LP1_MS   = 128;
   localparam int PERIOD_LP2_MS   = 1000;
   localparam int TOUCH_DEBOUNCE  = 2;
   localparam int FRAC_SHIFT      = 6;

   typedef enum {HALT_20S, HALT_40S, HALT_NEVER, HALT_ALWAYS} halt_mode_t;
   typedef enum {CHG_250KHZ, CHG_1MHZ} charge_freq_t;
   typedef enum {DET_IDLE, DET_ONE, DET_TOUCH} detect_state_t;

   typedef struct packed {
      logic        partial_tuning;
      logic [9:0]  prox_base;
      logic [7:0]  touch_base;
      logic [1:0]  halt_code;
      logic [5:0]  halt_seconds;
      logic [1:0]  sens_multiplier;
      logic [3:0]  base_multiplier;
      logic        charge_frequency_select;
      logic        stream_enable;
      logic        rf_noise_block_enable;
      logic [1:0]  sample_period_select;
      logic [9:0]  sample_period_ms;
      logic        guard_channel_enable;
      logic        active_high;
      logic [3:0]  retune_delay_s;
      logic [10:0] prox_target;
      logic [10:0] touch_target;
   } option_cfg_t;

   // threshold fraction numerator over 64
   function automatic logic [5:0] thr_fraction(input logic [2:0] code);
      case (code)
         3'h0:    thr_fraction = 6'd4;
         3'h1:    thr_fraction = 6'd1;
         3'h2:    thr_fraction = 6'd2;
         3'h3:    thr_fraction = 6'd8;
         3'h4:    thr_fraction = 6'd12;
         3'h5:    thr_fraction = 6'd16;
         3'h6:    thr_fraction = 6'd24;
         default: thr_fraction = 6'd32;
      endcase
   endfunction : thr_fraction
endpackage : touch_option_pkg

//--- touch_partner.sv
`timescale 1ns/1ps
`default_nettype none
module touch_partner (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // bench commands
   input  wire logic        go,
   input  wire logic [47:0] cs_in,
   input  wire logic [47:0] lta_in,
   // sample stream towards the block
   output logic             sample_valid,
   output logic      [47:0] sample_count,
   output logic      [47:0] long_term_average,
   // output pins
   input  wire logic [2:0]  pin_out,
   input  wire logic [2:0]  pin_oe,
   output logic      [2:0]  pin_level
);
   // =========================================================
   // sample source
   // counts flip every idle cycle so a stale value never looks valid
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sample_valid      <= 1'b0;
         sample_count      <= 48'h0;
         long_term_average <= 48'h0;
      end else begin
         sample_valid      <= go;
         sample_count      <= go ? cs_in : ~sample_count;
         long_term_average <= lta_in;
      end
   end
   // =========================================================
   // pin wires
   // pull-up: a released pin reads high
   assign pin_level = (pin_oe & pin_out) | ~pin_oe;
endmodule : touch_partner
`default_nettype wire
